// ---- rtl/hrl_map.svh ----
// Constants for the hub reset and link power sequencer.
// Assumes a 200 MHz core clock; all counts are in core clock cycles.
//
// Behaviour
// - Three resets: power-on, pin, upstream bus
// - Power-on reset held by internal timer
// - Pin reset low keeps standby low power
// - Pin reset disables PHYs, pairs high-Z
// - Pin reset aborts transactions, keeps no state
// - Pin reset returns registers to defaults
// - Pin reset halts oscillator and PLL
// - Bus reset clears address and configuration
// - Bus reset wakes suspended device to active
// - Bus reset never forwarded downstream
// - Link states L0, L1 sleep, L2 suspend
// - L1 entry under 10us, exit under 50us
// - L2 entry about 3ms, exit 2ms
`ifndef HRL_MAP_SVH
`define HRL_MAP_SVH

// Core clock period
`define HRL_CLK_PERIOD_NS  5
// Power-on hold time of the internal reset
`define HRL_POR_HOLD_NS    20000
// Link power latencies
`define HRL_L1_ENTRY_NS    10000
`define HRL_L1_EXIT_NS     50000
`define HRL_L2_ENTRY_NS    3000000
`define HRL_L2_EXIT_NS     2000000
// Cycles lost to timer load and state hand-off
`define HRL_HANDOFF_CYC    4
// Cycle counts derived from the times
`define HRL_POR_HOLD_CYC   (`HRL_POR_HOLD_NS / `HRL_CLK_PERIOD_NS)
`define HRL_L1_ENTRY_CYC   \
    (`HRL_L1_ENTRY_NS / `HRL_CLK_PERIOD_NS - `HRL_HANDOFF_CYC)
`define HRL_L1_EXIT_CYC    \
    (`HRL_L1_EXIT_NS / `HRL_CLK_PERIOD_NS - `HRL_HANDOFF_CYC)
`define HRL_L2_ENTRY_CYC   (`HRL_L2_ENTRY_NS / `HRL_CLK_PERIOD_NS)
`define HRL_L2_EXIT_CYC    (`HRL_L2_EXIT_NS / `HRL_CLK_PERIOD_NS)
// Timer width, enough for the longest count
`define HRL_TMR_W          20
// Reported link state codes
`define HRL_LS_L0          2'h0
`define HRL_LS_L1          2'h1
`define HRL_LS_L2          2'h2
// Field widths and reset values
`define HRL_ADDR_W         7
`define HRL_CFG_W          8
`define HRL_PCFG_W         4
`define HRL_ADDR_RST       7'h00
`define HRL_CFG_RST        8'h00
`define HRL_PCFG_RST       4'h0

`endif

// ---- rtl/hrl_pkg.sv ----
// Types shared by the hub reset and link power sequencer.
// Assumes nothing beyond the constants header.
package hrl_pkg;

    // Reset phase of the chip, Gray coded along power-up
    typedef enum logic [1:0] {
        PH_OFF   = 2'b00,  // Held in reset, clocks stopped
        PH_START = 2'b01,  // Clocks starting, hold timer running
        PH_RUN   = 2'b11   // Operating
    } hrl_phase_e;

    // Link power state machine, Gray coded along the sleep path only
    typedef enum logic [2:0] {
        LP_L0    = 3'b000,  // Fully on
        LP_L1ENT = 3'b001,  // Entering sleep
        LP_L1    = 3'b011,  // Sleep
        LP_L1EXT = 3'b010,  // Leaving sleep
        LP_L2ENT = 3'b110,  // Entering suspend
        LP_L2    = 3'b111,  // Suspend
        LP_L2EXT = 3'b101   // Resuming from suspend
    } hrl_link_e;

endpackage

// ---- rtl/hrl_timer.sv ----
// Down-counting latency timer with a one-cycle done pulse.
// Assumes load and clear come from flip-flops of the same clock.
module hrl_timer #(
    parameter int TW = 20
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Control
    input  wire logic          load,
    input  wire logic          clear,
    input  wire logic [TW-1:0] loadVal,
    // Status
    output logic               done,
    output logic               busy
);

    // Timer state
    typedef struct packed {
        logic [TW-1:0] cnt;   // Cycles left
        logic          done;  // Expiry pulse
    } hrl_tmr_s;

    hrl_tmr_s tmr_reg;  // Registered state
    hrl_tmr_s tmr_next; // Next state

    // Count down, pulse done on the last step
    always_comb begin
        tmr_next      = tmr_reg;
        tmr_next.done = 1'b0;
        if (clear) begin
            tmr_next.cnt = '0;
        end else if (load) begin
            tmr_next.cnt = loadVal;
        end else if (tmr_reg.cnt != '0) begin
            tmr_next.cnt  = tmr_reg.cnt - TW'(1);
            tmr_next.done = (tmr_reg.cnt == TW'(1));
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done = tmr_reg.done;
    assign busy = (tmr_reg.cnt != '0);

endmodule

// ---- rtl/hrl_rst_sync.sv ----
// Internal core reset: asserts at once, releases two edges after ready.
// Assumes srcRstN is glitch free; it is the AND of the power-on and pin resets.
module hrl_rst_sync (
    // Clock and combined reset source
    input  wire logic clk,
    input  wire logic srcRstN,
    // Release permission, synchronous to clk
    input  wire logic relOk,
    // Internal reset out
    output logic      coreRstN
);

    // Release pipeline state
    typedef struct packed {
        logic stage1;  // First release stage
        logic stage2;  // Released reset
    } hrl_rsync_s;

    hrl_rsync_s rs_reg;  // Registered state
    hrl_rsync_s rs_next; // Next state

    // Shift the release permission through two stages
    always_comb begin
        rs_next.stage1 = relOk;
        rs_next.stage2 = rs_reg.stage1 & relOk;
    end

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge srcRstN) begin
        if (!srcRstN) begin
            rs_reg <= '0;
        end else begin
            rs_reg <= rs_next;
        end
    end

    assign coreRstN = rs_reg.stage2;

endmodule

// ---- rtl/hrl_reset_power.sv ----
// Chip reset sequencing and link power state control for the hub.
// Assumes clk from oscillator/PLL, rst_n from the power-on detector,
// and all other inputs synchronous to clk.
`include "hrl_map.svh"

module hrl_reset_power #(
    parameter int TW        = `HRL_TMR_W,
    parameter int POR_CYC   = `HRL_POR_HOLD_CYC,
    parameter int L1ENT_CYC = `HRL_L1_ENTRY_CYC,
    parameter int L1EXT_CYC = `HRL_L1_EXIT_CYC,
    parameter int L2ENT_CYC = `HRL_L2_ENTRY_CYC,
    parameter int L2EXT_CYC = `HRL_L2_EXIT_CYC
) (
    // Clock and power-on reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // External reset pin and clock status
    input  wire logic                   extResetN,
    input  wire logic                   oscStable,
    input  wire logic                   pllStable,
    // Upstream port events
    input  wire logic                   busResetDet,
    input  wire logic                   l1Req,
    input  wire logic                   l1Wake,
    input  wire logic                   suspendDet,
    input  wire logic                   resumeDet,
    // Enumeration and configuration writes
    input  wire logic                   setAddrStb,
    input  wire logic [`HRL_ADDR_W-1:0] setAddrVal,
    input  wire logic                   setCfgStb,
    input  wire logic [`HRL_CFG_W-1:0]  setCfgVal,
    input  wire logic                   portCfgStb,
    input  wire logic [`HRL_PCFG_W-1:0] portCfgVal,
    // Clock and PHY control
    output logic                        oscEnable,
    output logic                        pllEnable,
    output logic                        standby,
    output logic                        phyEnable,
    output logic                        pairHiZ,
    output logic                        phyLowPower,
    output logic                        xactAbort,
    output logic                        coreRstN,
    // Device state
    output logic [`HRL_ADDR_W-1:0]      usbAddr,
    output logic [`HRL_CFG_W-1:0]       usbConfig,
    output logic [`HRL_PCFG_W-1:0]      portCfg,
    output logic [1:0]                  linkState,
    output logic                        suspended,
    output logic                        downResetFwd
);

    // Whole state of the sequencer
    typedef struct packed {
        hrl_pkg::hrl_phase_e     phase;     // Reset phase
        hrl_pkg::hrl_link_e      link;      // Link power state
        logic                    holdDone;  // Power-on hold elapsed
        logic                    holdLoad;  // Start hold timer
        logic                    tmrLoad;   // Start link timer
        logic                    tmrClear;  // Cancel link timer
        logic [TW-1:0]           tmrVal;    // Link timer count
        logic [TW-1:0]           entCnt;    // Cycles spent entering sleep
        logic                    oscEn;     // Oscillator enable
        logic                    pllEn;     // PLL enable
        logic                    stby;      // Standby mode
        logic                    phyEn;     // PHY enable
        logic                    hiZ;       // Pairs high impedance
        logic                    lowPwr;    // PHY in low power
        logic                    abort;     // Transactions aborted
        logic [`HRL_ADDR_W-1:0]  addr;      // Device address
        logic [`HRL_CFG_W-1:0]   cfg;       // Configuration value
        logic [`HRL_PCFG_W-1:0]  pcfg;      // Non-enumeration config
        logic [1:0]              lsCode;    // Reported link state
        logic                    susp;      // Suspended flag
        logic                    fwd;       // Downstream reset
    } hrl_core_s;

    // Defaults: clocks stopped, PHYs off, standby, registers cleared
    localparam hrl_core_s CORE_RST = '{
        phase:    hrl_pkg::PH_OFF,
        link:     hrl_pkg::LP_L0,
        holdDone: 1'b0,
        holdLoad: 1'b0,
        tmrLoad:  1'b0,
        tmrClear: 1'b1,
        tmrVal:   '0,
        entCnt:   '0,
        oscEn:    1'b0,
        pllEn:    1'b0,
        stby:     1'b1,
        phyEn:    1'b0,
        hiZ:      1'b1,
        lowPwr:   1'b0,
        abort:    1'b1,
        addr:     `HRL_ADDR_RST,
        cfg:      `HRL_CFG_RST,
        pcfg:     `HRL_PCFG_RST,
        lsCode:   `HRL_LS_L0,
        susp:     1'b0,
        fwd:      1'b0
    };

    hrl_core_s r_reg;   // Registered state
    hrl_core_s r_next;  // Next state

    logic holdPulse;  // Power-on hold expired
    logic linkDone;   // Link latency expired
    logic srcRstN;    // AND of power-on and pin resets

    // Cut a count to timer width
    function automatic logic [TW-1:0] cyc(input int n);
        cyc = n[TW-1:0];
    endfunction

    // Reported code for a link state
    function automatic logic [1:0] lsOf(input hrl_pkg::hrl_link_e s);
        unique case (s)
            hrl_pkg::LP_L1, hrl_pkg::LP_L1EXT:  lsOf = `HRL_LS_L1;
            hrl_pkg::LP_L2, hrl_pkg::LP_L2EXT:  lsOf = `HRL_LS_L2;
            default:                            lsOf = `HRL_LS_L0;
        endcase
    endfunction

    // Power-on hold timer, reloaded on each start from reset
    hrl_timer #(.TW(TW)) u_hold (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (r_reg.holdLoad),
        .clear   (r_reg.tmrClear),
        .loadVal (cyc(POR_CYC)),
        .done    (holdPulse),
        .busy    ()
    );

    // Link power latency timer
    hrl_timer #(.TW(TW)) u_link (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (r_reg.tmrLoad),
        .clear   (r_reg.tmrClear),
        .loadVal (r_reg.tmrVal),
        .done    (linkDone),
        .busy    ()
    );

    // Either reset source pulls the core reset down at once
    assign srcRstN = rst_n & extResetN;

    // Core reset released only once running with stable clocks
    hrl_rst_sync u_rsync (
        .clk      (clk),
        .srcRstN  (srcRstN),
        .relOk    (r_reg.phase == hrl_pkg::PH_RUN),
        .coreRstN (coreRstN)
    );

    // Next-state logic
    always_comb begin
        r_next          = r_reg;
        r_next.holdLoad = 1'b0;
        r_next.tmrLoad  = 1'b0;
        r_next.tmrClear = 1'b0;
        r_next.fwd      = 1'b0;
        if (!extResetN) begin
            // Pin reset: standby, PHYs off, clocks off, all cleared
            r_next = CORE_RST;
        end else begin
            unique case (r_reg.phase)
                hrl_pkg::PH_OFF: begin
                    // Restart clocks and the hold timer
                    r_next.oscEn    = 1'b1;
                    r_next.pllEn    = 1'b1;
                    r_next.stby     = 1'b0;
                    r_next.holdLoad = 1'b1;
                    r_next.phase    = hrl_pkg::PH_START;
                end
                hrl_pkg::PH_START: begin
                    // Wait for hold time and stable clocks
                    r_next.holdDone = r_reg.holdDone | holdPulse;
                    if (r_reg.holdDone && oscStable && pllStable) begin
                        r_next.phase = hrl_pkg::PH_RUN;
                        r_next.phyEn = 1'b1;
                        r_next.hiZ   = 1'b0;
                        r_next.abort = 1'b0;
                    end
                end
                hrl_pkg::PH_RUN: begin
                    // Configuration unrelated to enumeration
                    r_next.pcfg = portCfgStb ? portCfgVal : r_reg.pcfg;
                    if (busResetDet) begin
                        // Bus reset: device state only, clocks untouched
                        r_next.addr     = `HRL_ADDR_RST;
                        r_next.cfg      = `HRL_CFG_RST;
                        r_next.link     = hrl_pkg::LP_L0;
                        r_next.lowPwr   = 1'b0;
                        r_next.tmrClear = 1'b1;
                    end else begin
                        r_next.addr = setAddrStb ? setAddrVal : r_reg.addr;
                        r_next.cfg  = setCfgStb ? setCfgVal : r_reg.cfg;
                        unique case (r_reg.link)
                            hrl_pkg::LP_L0: begin
                                // Sleep request wins over suspend
                                if (l1Req) begin
                                    r_next.link    = hrl_pkg::LP_L1ENT;
                                    r_next.tmrVal  = cyc(L1ENT_CYC);
                                    r_next.tmrLoad = 1'b1;
                                end else if (suspendDet) begin
                                    r_next.link    = hrl_pkg::LP_L2ENT;
                                    r_next.tmrVal  = cyc(L2ENT_CYC);
                                    r_next.tmrLoad = 1'b1;
                                end
                            end
                            hrl_pkg::LP_L1ENT: begin
                                // Enter sleep when entry time elapses
                                if (linkDone) begin
                                    r_next.link   = hrl_pkg::LP_L1;
                                    r_next.lowPwr = 1'b1;
                                end
                            end
                            hrl_pkg::LP_L1: begin
                                // Wake from sleep
                                if (l1Wake || resumeDet) begin
                                    r_next.link    = hrl_pkg::LP_L1EXT;
                                    r_next.tmrVal  = cyc(L1EXT_CYC);
                                    r_next.tmrLoad = 1'b1;
                                end
                            end
                            hrl_pkg::LP_L2ENT: begin
                                // Enter suspend when entry time elapses
                                if (linkDone) begin
                                    r_next.link   = hrl_pkg::LP_L2;
                                    r_next.lowPwr = 1'b1;
                                end
                            end
                            hrl_pkg::LP_L2: begin
                                // Resume signalling starts exit
                                if (resumeDet) begin
                                    r_next.link    = hrl_pkg::LP_L2EXT;
                                    r_next.tmrVal  = cyc(L2EXT_CYC);
                                    r_next.tmrLoad = 1'b1;
                                end
                            end
                            hrl_pkg::LP_L1EXT, hrl_pkg::LP_L2EXT: begin
                                // Back to fully on after exit time
                                if (linkDone) begin
                                    r_next.link   = hrl_pkg::LP_L0;
                                    r_next.lowPwr = 1'b0;
                                end
                            end
                            default: begin
                                // Illegal code recovers to fully on
                                r_next.link = hrl_pkg::LP_L0;
                            end
                        endcase
                    end
                end
                default: begin
                    // Illegal phase restarts the power-up
                    r_next = CORE_RST;
                end
            endcase
        end
        r_next.lsCode = lsOf(r_next.link);
        r_next.susp   = (r_next.link == hrl_pkg::LP_L2);
        r_next.entCnt = (r_next.link == hrl_pkg::LP_L1ENT)
                        ? r_reg.entCnt + TW'(1) : '0;
    end

    // State register, power-on reset asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= CORE_RST;
        end else begin
            r_reg <= r_next;
        end
    end
    // Outputs straight from the state register
    assign oscEnable    = r_reg.oscEn;
    assign pllEnable    = r_reg.pllEn;
    assign standby      = r_reg.stby;
    assign phyEnable    = r_reg.phyEn;
    assign pairHiZ      = r_reg.hiZ;
    assign phyLowPower  = r_reg.lowPwr;
    assign xactAbort    = r_reg.abort;
    assign usbAddr      = r_reg.addr;
    assign usbConfig    = r_reg.cfg;
    assign portCfg      = r_reg.pcfg;
    assign linkState    = r_reg.lsCode;
    assign suspended    = r_reg.susp;
    assign downResetFwd = r_reg.fwd;

    // Checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pin_standby: assert property (!extResetN |=> standby)
        else $error("standby not entered under pin reset");
    a_pin_phy_off: assert property (
        !extResetN |=> !phyEnable && pairHiZ)
        else $error("PHY still driving under pin reset");
    a_pin_abort: assert property (
        !extResetN |=> xactAbort && linkState == `HRL_LS_L0)
        else $error("state kept under pin reset");
    a_pin_defaults: assert property (
        !extResetN |=> usbAddr == '0 && usbConfig == '0 && portCfg == '0)
        else $error("registers not defaulted by pin reset");
    a_pin_clk_halt: assert property (
        !extResetN |=> !oscEnable && !pllEnable)
        else $error("oscillator or PLL running under pin reset");
    a_bus_clear: assert property (
        extResetN && busResetDet && r_reg.phase == hrl_pkg::PH_RUN
        |=> usbAddr == '0 && usbConfig == '0)
        else $error("bus reset did not clear address or config");
    a_bus_wake: assert property (
        extResetN && busResetDet && suspended
        |=> !suspended && !phyLowPower)
        else $error("bus reset left device suspended");
    a_no_forward: assert property (!downResetFwd)
        else $error("bus reset forwarded downstream");
    a_link_code: assert property (linkState != 2'h3)
        else $error("illegal link state code");
    a_l1_entry: assert property (
        r_reg.link == hrl_pkg::LP_L1ENT
        |-> r_reg.entCnt <= cyc(L1ENT_CYC + 2))
        else $error("L1 entry took too long");
    a_l2_entry: assert property (
        extResetN && !busResetDet && linkDone
        && r_reg.link == hrl_pkg::LP_L2ENT |=> suspended)
        else $error("L2 not entered on expiry");
    a_core_release: assert property (
        $rose(coreRstN) |-> oscStable && pllStable
        && $past(r_reg.phase) == hrl_pkg::PH_RUN)
        else $error("core reset released too early");
    a_por_hold: assert property (
        r_reg.phase == hrl_pkg::PH_START |-> !coreRstN)
        else $error("core reset released during hold");
    a_bus_keep_clk: assert property (
        extResetN && busResetDet && oscEnable
        |=> oscEnable && pllEnable && $stable(portCfg))
        else $error("bus reset disturbed clocks or config");
endmodule

// ---- tb/hrl_clk_status_model.sv ----
// Board-side oscillator and PLL status model for the reset sequencer.
// Assumes the enables come from flip-flops clocked by clk.
module hrl_clk_status_model #(
    parameter int SETTLE = 6  // Start-up cycles, a plain default
) (
    // Clock and enables from the block
    input  wire logic clk,
    input  wire logic oscEnable,
    input  wire logic pllEnable,
    // Stable flags back to the block
    output logic      oscStable,
    output logic      pllStable
);
    timeunit 1ns;
    timeprecision 1ps;
    int oscCnt;  // Cycles since oscillator enable
    int pllCnt;  // Cycles since PLL enable with oscillator running
    // A halted source loses its flag at once; no stale stable level
    assign oscStable = oscEnable && (oscCnt >= SETTLE);
    assign pllStable = pllEnable && oscStable && (pllCnt >= SETTLE);
    // Start-up counters, the PLL only locks on a running oscillator
    always @(posedge clk) begin
        oscCnt <= oscEnable ? ((oscCnt < SETTLE) ? oscCnt + 1 : oscCnt) : 0;
        pllCnt <= (pllEnable && oscStable)
                  ? ((pllCnt < SETTLE) ? pllCnt + 1 : pllCnt) : 0;
    end
endmodule

// ---- tb/hrl_reset_power_tb_top.sv ----
// Self-checking bench for the hub reset and link power sequencer.
// Assumes the design files and the clock status model are compiled first.
`include "hrl_map.svh"
module hrl_reset_power_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR = 20, L1E = 10, L1X = 20, L2E = 50, L2X = 40;
    // Stimulus
    logic clk, rst_n, extResetN, busResetDet, l1Req, l1Wake;
    logic suspendDet, resumeDet, setAddrStb, setCfgStb, portCfgStb;
    logic [`HRL_ADDR_W-1:0] setAddrVal, usbAddr;
    logic [`HRL_CFG_W-1:0]  setCfgVal, usbConfig;
    logic [`HRL_PCFG_W-1:0] portCfgVal, portCfg;
    // Observed
    logic oscStable, pllStable, oscEnable, pllEnable, standby, phyEnable;
    logic pairHiZ, phyLowPower, xactAbort, coreRstN, suspended, downResetFwd;
    logic [1:0] linkState;
    int errors, n_compared;
    // Device under test with shortened counts
    hrl_reset_power #(.TW(20), .POR_CYC(POR), .L1ENT_CYC(L1E),
        .L1EXT_CYC(L1X), .L2ENT_CYC(L2E), .L2EXT_CYC(L2X)) i_dut (
        .clk(clk), .rst_n(rst_n), .extResetN(extResetN),
        .oscStable(oscStable), .pllStable(pllStable),
        .busResetDet(busResetDet), .l1Req(l1Req), .l1Wake(l1Wake),
        .suspendDet(suspendDet), .resumeDet(resumeDet),
        .setAddrStb(setAddrStb), .setAddrVal(setAddrVal),
        .setCfgStb(setCfgStb), .setCfgVal(setCfgVal),
        .portCfgStb(portCfgStb), .portCfgVal(portCfgVal),
        .oscEnable(oscEnable), .pllEnable(pllEnable), .standby(standby),
        .phyEnable(phyEnable), .pairHiZ(pairHiZ), .phyLowPower(phyLowPower),
        .xactAbort(xactAbort), .coreRstN(coreRstN), .usbAddr(usbAddr),
        .usbConfig(usbConfig), .portCfg(portCfg), .linkState(linkState),
        .suspended(suspended), .downResetFwd(downResetFwd));
    // Oscillator and PLL on the board
    hrl_clk_status_model i_clks (.clk(clk), .oscEnable(oscEnable),
        .pllEnable(pllEnable), .oscStable(oscStable), .pllStable(pllStable));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask
    // Advance n edges, then settle
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle event strobe
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    // Count cycles until the link shows a state, bounded
    task automatic wait_ls(input logic [1:0] ls, output int n);
        n = 0;
        while (linkState !== ls && n < 1000) begin
            step(1);
            n++;
        end
    endtask
    // Wait for the internal reset to release
    task automatic bring_up(output int n);
        n = 0;
        while (coreRstN !== 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        chk({phyEnable, pairHiZ, xactAbort}, 3'h4, "phy on");
    endtask
    // Values held during reset, then power-on hold length
    task automatic t_power_on();
        int n;
        chk({standby, phyEnable, pairHiZ, xactAbort}, 4'hB, "reset pins");
        chk({oscEnable, pllEnable, coreRstN}, 3'h0, "clocks in reset");
        rst_n = 1'b1;
        bring_up(n);
        chk(n >= POR, 1'b1, "power-on hold");
        chk(standby, 1'b0, "standby off");
    endtask
    // Enumeration writes, then bus reset with a refused address write
    task automatic t_bus_reset();
        setAddrStb = 1'b1; setAddrVal = 7'h2A; setCfgStb = 1'b1;
        setCfgVal = 8'h03; portCfgStb = 1'b1; portCfgVal = 4'hA;
        step(1);
        setCfgStb = 1'b0; portCfgStb = 1'b0;
        chk({usbAddr, usbConfig}, {7'h2A, 8'h03}, "written");
        busResetDet = 1'b1; setAddrVal = 7'h55;
        step(1);
        busResetDet = 1'b0; setAddrStb = 1'b0;
        chk({usbAddr, usbConfig}, 15'h0000, "bus reset clears");
        chk(portCfg, 4'hA, "port config kept");
        chk({oscEnable, pllEnable, coreRstN}, 3'h7, "clocks run");
        chk(downResetFwd, 1'b0, "not forwarded");
    endtask
    // Sleep entry and exit latency
    task automatic t_sleep();
        int n;
        pulse(l1Req);
        wait_ls(`HRL_LS_L1, n);
        chk(n >= L1E && n <= L1E + 5, 1'b1, "sleep entry");
        chk(phyLowPower, 1'b1, "phy low power");
        pulse(l1Wake);
        wait_ls(`HRL_LS_L0, n);
        chk(n >= L1X && n <= L1X + 5, 1'b1, "sleep exit");
    endtask
    // Suspend, resume, then bus reset out of suspend
    task automatic t_suspend();
        int n;
        pulse(suspendDet);
        wait_ls(`HRL_LS_L2, n);
        chk(n >= L2E && n <= L2E + 5, 1'b1, "suspend entry");
        chk(suspended, 1'b1, "suspended");
        pulse(resumeDet);
        wait_ls(`HRL_LS_L0, n);
        chk(n >= L2X && n <= L2X + 5, 1'b1, "resume");
        pulse(suspendDet);
        wait_ls(`HRL_LS_L2, n);
        chk(suspended, 1'b1, "suspended again");
        pulse(busResetDet);
        chk({suspended, linkState}, 3'h0, "woken by bus reset");
    endtask
    // Pin reset in mid-run, then restart
    task automatic t_pin_reset();
        int n;
        extResetN = 1'b0;
        #1;
        chk(coreRstN, 1'b0, "core reset at once");
        step(1);
        chk({standby, phyEnable, pairHiZ}, 3'h5, "phy off, hi-z");
        chk(xactAbort, 1'b1, "transactions aborted");
        chk({usbAddr, portCfg}, 11'h000, "defaults");
        step(4);
        chk({oscEnable, pllEnable}, 2'h0, "clocks halted");
        extResetN = 1'b1;
        bring_up(n);
    endtask
    // Verdict
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, extResetN, busResetDet, l1Req, l1Wake} = 5'b01000;
        {suspendDet, resumeDet, setAddrStb, setCfgStb, portCfgStb} = 5'b0;
        setAddrVal = 7'h00; setCfgVal = 8'h00; portCfgVal = 4'h0;
        errors = 0; n_compared = 0;
        step(6);
        t_power_on();
        t_bus_reset();
        t_sleep();
        t_suspend();
        t_pin_reset();
        end_of_test();
    end
    // Watchdog
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule
